// ---- logic/wce_pkg.sv ----
`default_nettype none
package wce_pkg;
  // Sample and channel geometry
  localparam int WCE_DATA_W = 12;
  localparam int WCE_CHAN_N = 2;
  localparam int WCE_CHAN_W = 1;
  localparam int WCE_BUF_DEPTH = 16;
  // Consecutive-hit field and counter widths
  localparam int WCE_CNT_FIELD_W = 4;
  localparam int WCE_HIT_W = 5;
  // Threshold assembly widths
  localparam int WCE_BYTE_W = 8;
  localparam int WCE_NIBBLE_W = 4;
  // Codes with special meaning at the window edges
  localparam logic [WCE_DATA_W-1:0] WCE_FULL_SCALE = 12'hFFF;
  localparam logic [WCE_DATA_W-1:0] WCE_ZERO_CODE = 12'h000;
  // Hit counter reset and increment values
  localparam logic [WCE_HIT_W-1:0] WCE_HIT_RESET = 5'h00;
  localparam logic [WCE_HIT_W-1:0] WCE_HIT_ONE = 5'h01;

  typedef enum logic {
    WCE_MODE_PRE,
    WCE_MODE_POST
  } wce_mode_t;

  typedef enum logic [2:0] {
    WCE_ST_OFF,
    WCE_ST_PRE,
    WCE_ST_WAIT,
    WCE_ST_FILL,
    WCE_ST_DONE
  } wce_state_t;
endpackage
`default_nettype wire

// ---- logic/wce_buf_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface wce_buf_if #(
  parameter int WIDTH = 12
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic full;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic rd_data_valid;
  logic flush;

  modport ctrl (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, full, rd_valid, rd_data, rd_data_valid
  );
  modport store (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, full, rd_valid, rd_data, rd_data_valid
  );
endinterface
`default_nettype wire

// ---- logic/wce_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module wce_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  wce_buf_if.store bus
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap by themselves
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("wce_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] count_q, count_d;
  logic full_q, full_d, nempty_q, nempty_d;
  logic [WIDTH-1:0] rd_data_q, rd_data_d;
  logic rd_dv_q, rd_dv_d;
  logic push, pop;

  // A full store still accepts a word when the oldest leaves in the same cycle
  assign bus.wr_ready = !full_q || bus.rd_ready;
  assign bus.full = full_q;
  assign bus.rd_valid = nempty_q;
  assign bus.rd_data = rd_data_q;
  assign bus.rd_data_valid = rd_dv_q;
  assign push = bus.wr_valid && bus.wr_ready;
  assign pop = bus.rd_valid && bus.rd_ready;

  // Pointer, level and read-register next values
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    rd_data_d = rd_data_q;
    rd_dv_d = pop;
    if (pop) begin
      rd_data_d = mem_q[rd_ptr_q];
      rd_ptr_d = rd_ptr_q + AW'(1);
    end
    if (push) begin
      wr_ptr_d = wr_ptr_q + AW'(1);
    end
    if (push && !pop) begin
      count_d = count_q + (AW+1)'(1);
    end else if (pop && !push) begin
      count_d = count_q - (AW+1)'(1);
    end
    if (bus.flush) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = '0;
    end
    full_d = (count_d == (AW+1)'(DEPTH));
    nempty_d = (count_d != '0);
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      full_q <= 1'b0;
      nempty_q <= 1'b0;
      rd_data_q <= '0;
      rd_dv_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      full_q <= full_d;
      nempty_q <= nempty_d;
      rd_data_q <= rd_data_d;
      rd_dv_q <= rd_dv_d;
    end
  end

  // Storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= bus.wr_data;
    end
  end
endmodule
`default_nettype wire

// ---- logic/wce_window_capture.sv ----
`timescale 1ns/100ps
`default_nettype none
module wce_window_capture #(
  parameter int DEPTH = wce_pkg::WCE_BUF_DEPTH
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SAMPLE_VALID,
  input wire logic [wce_pkg::WCE_DATA_W-1:0] SAMPLE_DATA,
  input wire logic [wce_pkg::WCE_CHAN_W-1:0] SAMPLE_CHAN,
  input wire logic WINDOW_COMPARE_ENABLE,
  input wire logic CHAN0_EVENT_ENABLE,
  input wire logic CHAN1_EVENT_ENABLE,
  input wire logic [wce_pkg::WCE_CNT_FIELD_W-1:0] CONSECUTIVE_HIT_COUNT,
  input wire logic [wce_pkg::WCE_BYTE_W-1:0] CHAN0_UPPER_BOUND_LOW_BYTE,
  input wire logic [wce_pkg::WCE_NIBBLE_W-1:0] CHAN0_UPPER_BOUND_HIGH_NIBBLE,
  input wire logic [wce_pkg::WCE_BYTE_W-1:0] CHAN0_LOWER_BOUND_LOW_BYTE,
  input wire logic [wce_pkg::WCE_NIBBLE_W-1:0] CHAN0_LOWER_BOUND_HIGH_NIBBLE,
  input wire logic [wce_pkg::WCE_BYTE_W-1:0] CHAN1_UPPER_BOUND_LOW_BYTE,
  input wire logic [wce_pkg::WCE_NIBBLE_W-1:0] CHAN1_UPPER_BOUND_HIGH_NIBBLE,
  input wire logic [wce_pkg::WCE_BYTE_W-1:0] CHAN1_LOWER_BOUND_LOW_BYTE,
  input wire logic [wce_pkg::WCE_NIBBLE_W-1:0] CHAN1_LOWER_BOUND_HIGH_NIBBLE,
  input wire wce_pkg::wce_mode_t CAPTURE_MODE,
  input wire logic REARM,
  input wire logic READ_REQ,
  input wire logic ALERT_N_IN,
  output logic ALERT_N_OUT,
  output logic ALERT_N_OE,
  output logic CAPTURE_DONE,
  output logic BUFFER_AVAIL,
  output logic [wce_pkg::WCE_DATA_W-1:0] READ_DATA,
  output logic READ_DATA_VALID
);
  import wce_pkg::*;

  // Capture length is the buffer depth; the counter must reach it
  if (DEPTH != WCE_BUF_DEPTH) begin : g_bad_depth
    $error("wce_window_capture: DEPTH must equal the capture length");
  end

  logic [WCE_DATA_W-1:0] upper [WCE_CHAN_N];
  logic [WCE_DATA_W-1:0] lower [WCE_CHAN_N];
  logic [WCE_CHAN_N-1:0] chan_en, active, filt_d;
  logic [WCE_HIT_W-1:0] need;
  logic alert_q, alert_d, trigger;
  wce_state_t state_q, state_d;
  logic [WCE_HIT_W-1:0] cap_cnt_q, cap_cnt_d;
  logic done_q, done_d, avail_q, avail_d, zero_q, rd_dv_q, rd_dv_d;

  wce_buf_if #(.WIDTH(WCE_DATA_W)) buf_if ();

  // Threshold assembly from byte and nibble fields
  assign upper[0] = {CHAN0_UPPER_BOUND_HIGH_NIBBLE, CHAN0_UPPER_BOUND_LOW_BYTE};
  assign lower[0] = {CHAN0_LOWER_BOUND_HIGH_NIBBLE, CHAN0_LOWER_BOUND_LOW_BYTE};
  assign upper[1] = {CHAN1_UPPER_BOUND_HIGH_NIBBLE, CHAN1_UPPER_BOUND_LOW_BYTE};
  assign lower[1] = {CHAN1_LOWER_BOUND_HIGH_NIBBLE, CHAN1_LOWER_BOUND_LOW_BYTE};
  assign chan_en = {CHAN1_EVENT_ENABLE, CHAN0_EVENT_ENABLE};
  assign active = chan_en & {WCE_CHAN_N{WINDOW_COMPARE_ENABLE}};
  assign need = {1'b0, CONSECUTIVE_HIT_COUNT} + WCE_HIT_ONE;

  // Per-channel comparators and consecutive-hit filters
  for (genvar c = 0; c < WCE_CHAN_N; c++) begin : g_chan
    logic [WCE_HIT_W-1:0] hit_lo_q, hit_lo_d, hit_hi_q, hit_hi_d;
    logic lo_cmp, hi_cmp, this_ch, filt_c;

    // Inclusive compares; 0xFFF or 0x000 bounds leave only the exact code
    assign lo_cmp = (SAMPLE_DATA <= lower[c]);
    assign hi_cmp = (SAMPLE_DATA >= upper[c]);
    assign this_ch = SAMPLE_VALID && (SAMPLE_CHAN == WCE_CHAN_W'(c));

    // Count up to the required run, restart on a miss
    always_comb begin
      hit_lo_d = hit_lo_q;
      hit_hi_d = hit_hi_q;
      if (!active[c]) begin
        hit_lo_d = WCE_HIT_RESET;
        hit_hi_d = WCE_HIT_RESET;
      end else if (this_ch) begin
        hit_lo_d = !lo_cmp ? WCE_HIT_RESET : (hit_lo_q < need) ? hit_lo_q + WCE_HIT_ONE
                 : hit_lo_q;
        hit_hi_d = !hi_cmp ? WCE_HIT_RESET : (hit_hi_q < need) ? hit_hi_q + WCE_HIT_ONE
                 : hit_hi_q;
      end
      filt_c = active[c] && (hit_lo_d >= need || hit_hi_d >= need);
    end

    // One continuous driver per bit of the shared vector
    assign filt_d[c] = filt_c;

    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        hit_lo_q <= WCE_HIT_RESET;
        hit_hi_q <= WCE_HIT_RESET;
      end else begin
        hit_lo_q <= hit_lo_d;
        hit_hi_q <= hit_hi_d;
      end
    end
  end

  // Event is any enabled filtered hit; trigger is the conversion raising it
  assign alert_d = |filt_d;
  assign trigger = SAMPLE_VALID && alert_d && !alert_q;

  // Capture sequencer
  always_comb begin
    state_d = state_q;
    cap_cnt_d = cap_cnt_q;
    buf_if.wr_valid = 1'b0;
    buf_if.wr_data = SAMPLE_DATA;
    buf_if.rd_ready = 1'b0;
    buf_if.flush = 1'b0;
    rd_dv_d = 1'b0;
    case (state_q)
      WCE_ST_OFF: begin
        if (WINDOW_COMPARE_ENABLE) begin
          buf_if.flush = 1'b1;
          cap_cnt_d = WCE_HIT_RESET;
          state_d = (CAPTURE_MODE == WCE_MODE_PRE) ? WCE_ST_PRE : WCE_ST_WAIT;
        end
      end
      WCE_ST_PRE: begin
        if (!WINDOW_COMPARE_ENABLE) begin
          state_d = WCE_ST_OFF;
        end else if (SAMPLE_VALID) begin
          buf_if.wr_valid = 1'b1;
          buf_if.rd_ready = buf_if.full; // Drop oldest to keep a rolling window
          if (trigger) begin
            state_d = WCE_ST_DONE;
          end
        end
      end
      WCE_ST_WAIT: begin
        if (!WINDOW_COMPARE_ENABLE) begin
          state_d = WCE_ST_OFF;
        end else if (trigger) begin
          buf_if.wr_valid = 1'b1;
          cap_cnt_d = WCE_HIT_ONE;
          state_d = WCE_ST_FILL;
        end
      end
      WCE_ST_FILL: begin
        if (!WINDOW_COMPARE_ENABLE) begin
          state_d = WCE_ST_OFF;
        end else if (SAMPLE_VALID) begin
          buf_if.wr_valid = 1'b1;
          if (buf_if.wr_ready) begin
            cap_cnt_d = cap_cnt_q + WCE_HIT_ONE;
            if (cap_cnt_d == WCE_HIT_W'(DEPTH)) begin
              state_d = WCE_ST_DONE;
            end
          end
        end
      end
      WCE_ST_DONE: begin
        buf_if.rd_ready = READ_REQ;
        rd_dv_d = READ_REQ && buf_if.rd_valid; // Host pops only, never rolling drops
        if (REARM) begin
          state_d = WCE_ST_OFF;
        end
      end
      default: begin
        state_d = WCE_ST_OFF;
      end
    endcase
    done_d = (state_d == WCE_ST_DONE);
    avail_d = done_d && buf_if.rd_valid;
  end

  // Sequencer, event and output registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= WCE_ST_OFF;
      cap_cnt_q <= WCE_HIT_RESET;
      alert_q <= 1'b0;
      done_q <= 1'b0;
      avail_q <= 1'b0;
      zero_q <= 1'b0;
      rd_dv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cap_cnt_q <= cap_cnt_d;
      alert_q <= alert_d;
      done_q <= done_d;
      avail_q <= avail_d;
      zero_q <= 1'b0;
      rd_dv_q <= rd_dv_d;
    end
  end

  // Open drain: pin only ever driven low, enable carries the event
  assign ALERT_N_OUT = zero_q;
  assign ALERT_N_OE = alert_q;
  assign CAPTURE_DONE = done_q;
  assign BUFFER_AVAIL = avail_q;
  assign READ_DATA = buf_if.rd_data;
  assign READ_DATA_VALID = rd_dv_q;

  wce_fifo #(
    .WIDTH(WCE_DATA_W),
    .DEPTH(DEPTH)
  ) u_buf (
    .clk(CLK),
    .rst_n(RST_N),
    .bus(buf_if)
  );
endmodule
`default_nettype wire

// ---- verif/wce_host_mdl.sv ----
`timescale 1ns/100ps
`default_nettype none
module wce_host_mdl (
  input wire logic oe,
  input wire logic drv,
  output logic pin,
  output var int wakes
);
  // Pull-up holds the line high unless the device sinks it
  assign pin = oe ? drv : 1'h1;
  // Host wakes on each falling edge of the event line
  initial wakes = 0;
  always @(negedge pin) wakes++;
endmodule
`default_nettype wire

// ---- verif/wce_wc_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module wce_wc_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SAMPLE_VALID,
  input wire logic WINDOW_COMPARE_ENABLE,
  input wire logic CHAN0_EVENT_ENABLE,
  input wire logic CHAN1_EVENT_ENABLE,
  input wire wce_pkg::wce_mode_t CAPTURE_MODE,
  input wire logic REARM,
  input wire logic READ_REQ,
  input wire logic ALERT_N_OUT,
  input wire logic ALERT_N_OE,
  input wire logic CAPTURE_DONE,
  input wire logic READ_DATA_VALID
);
  import wce_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Event pin, read-out and capture state relations
  property p_low;
    ALERT_N_OUT == 1'h0;
  endproperty
  a_low: assert property (p_low) else $error("pin driven high");
  property p_nochan;
    (!CHAN0_EVENT_ENABLE && !CHAN1_EVENT_ENABLE) [*2] |-> !ALERT_N_OE;
  endproperty
  a_nochan: assert property (p_nochan) else $error("event while masked");
  property p_off;
    (!WINDOW_COMPARE_ENABLE && !CAPTURE_DONE) [*3] |-> !ALERT_N_OE;
  endproperty
  a_off: assert property (p_off) else $error("event while off");
  property p_rd;
    READ_DATA_VALID |-> $past(READ_REQ) && $past(CAPTURE_DONE);
  endproperty
  a_rd: assert property (p_rd) else $error("read without request");
  property p_hold;
    CAPTURE_DONE && !REARM |=> CAPTURE_DONE;
  endproperty
  a_hold: assert property (p_hold) else $error("capture lost");
  property p_rearm;
    CAPTURE_DONE && REARM |-> ##[1:3] !CAPTURE_DONE;
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm ignored");
  property p_rise;
    $rose(ALERT_N_OE) |-> $past(SAMPLE_VALID);
  endproperty
  a_rise: assert property (p_rise) else $error("event without sample");
  property p_pre;
    $rose(CAPTURE_DONE) && CAPTURE_MODE == WCE_MODE_PRE |-> $rose(ALERT_N_OE);
  endproperty
  a_pre: assert property (p_pre) else $error("pre stop off trigger");
  c_pre: cover property ($rose(CAPTURE_DONE) && CAPTURE_MODE == WCE_MODE_PRE);
  c_post: cover property ($rose(CAPTURE_DONE) && CAPTURE_MODE == WCE_MODE_POST);
  c_read: cover property (READ_DATA_VALID);
endmodule
bind wce_window_capture wce_wc_chk u_chk (
  .CLK(CLK),
  .RST_N(RST_N),
  .SAMPLE_VALID(SAMPLE_VALID),
  .WINDOW_COMPARE_ENABLE(WINDOW_COMPARE_ENABLE),
  .CHAN0_EVENT_ENABLE(CHAN0_EVENT_ENABLE),
  .CHAN1_EVENT_ENABLE(CHAN1_EVENT_ENABLE),
  .CAPTURE_MODE(CAPTURE_MODE),
  .REARM(REARM),
  .READ_REQ(READ_REQ),
  .ALERT_N_OUT(ALERT_N_OUT),
  .ALERT_N_OE(ALERT_N_OE),
  .CAPTURE_DONE(CAPTURE_DONE),
  .READ_DATA_VALID(READ_DATA_VALID)
);
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wce_pkg::*;
  logic clk, rst_n, sv, sc, rearm, rreq, ge, e0, e1, oe, drv, done, avail, rdv, pin;
  logic [11:0] sd, rdat;
  logic [11:0] th [4];
  logic [3:0] cnt;
  wce_mode_t mode;
  int mismatches, cmp_count, wakes;
  logic [11:0] q [$];
  logic [11:0] keep [$];

  wce_window_capture u_dut (
    .CLK(clk),
    .RST_N(rst_n),
    .SAMPLE_VALID(sv),
    .SAMPLE_DATA(sd),
    .SAMPLE_CHAN(sc),
    .WINDOW_COMPARE_ENABLE(ge),
    .CHAN0_EVENT_ENABLE(e0),
    .CHAN1_EVENT_ENABLE(e1),
    .CONSECUTIVE_HIT_COUNT(cnt),
    .CHAN0_UPPER_BOUND_LOW_BYTE(th[1][7:0]),
    .CHAN0_UPPER_BOUND_HIGH_NIBBLE(th[1][11:8]),
    .CHAN0_LOWER_BOUND_LOW_BYTE(th[0][7:0]),
    .CHAN0_LOWER_BOUND_HIGH_NIBBLE(th[0][11:8]),
    .CHAN1_UPPER_BOUND_LOW_BYTE(th[3][7:0]),
    .CHAN1_UPPER_BOUND_HIGH_NIBBLE(th[3][11:8]),
    .CHAN1_LOWER_BOUND_LOW_BYTE(th[2][7:0]),
    .CHAN1_LOWER_BOUND_HIGH_NIBBLE(th[2][11:8]),
    .CAPTURE_MODE(mode),
    .REARM(rearm),
    .READ_REQ(rreq),
    .ALERT_N_IN(pin),
    .ALERT_N_OUT(drv),
    .ALERT_N_OE(oe),
    .CAPTURE_DONE(done),
    .BUFFER_AVAIL(avail),
    .READ_DATA(rdat),
    .READ_DATA_VALID(rdv)
  );
  wce_host_mdl u_host (.oe(oe), .drv(drv), .pin(pin), .wakes(wakes));

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One conversion per cycle; the model keeps the newest sixteen
  task automatic smp(input logic c, input logic [11:0] d);
    @(posedge clk);
    #1 sv = 1'h1;
    sc = c;
    sd = d;
    q.push_back(d);
    if (q.size() > 16) void'(q.pop_front());
  endtask
  task automatic idle();
    @(posedge clk);
    #1 sv = 1'h0;
  endtask
  task automatic rd1();
    @(posedge clk);
    #1 rreq = 1'h1;
    @(posedge clk);
    #1 rreq = 1'h0;
  endtask
  task automatic rd_all();
    while (q.size() > 0) begin
      rd1();
      chk(rdv, 1'h1);
      chk(rdat, q.pop_front());
    end
    rd1();
    chk(rdv, 1'h0);
    chk(avail, 1'h0);
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin : main
    int i;
    {rst_n, sv, sc, rearm, rreq, ge, e0, e1} = '0;
    sd = 12'h000;
    cnt = 4'h2;
    mode = WCE_MODE_PRE;
    th = '{12'h100, 12'hE00, 12'h100, 12'hE00};
    repeat (16) @(posedge clk);
    #1 rst_n = 1'h1;
    chk(oe, 1'h0);
    chk(pin, 1'h1);
    @(posedge clk);
    #1 ge = 1'h1;
    e0 = 1'h1;
    // Channel 1 hits while its enable is clear
    for (i = 0; i < 5; i++) smp(1'h1, 12'h000);
    idle();
    chk(oe, 1'h0);
    for (i = 0; i < 20; i++) smp(i[0], 12'h400 + 12'(i));
    // Two hits, a break, then three hits with count field 2
    smp(1'h0, 12'h100);
    smp(1'h0, 12'h050);
    smp(1'h0, 12'h400);
    smp(1'h0, 12'h0FF);
    smp(1'h0, 12'h100);
    idle();
    chk(oe, 1'h0);
    smp(1'h0, 12'h000);
    idle();
    chk(oe, 1'h1);
    chk(done, 1'h1);
    chk(pin, 1'h0);
    chk(12'(wakes), 12'h001);
    keep = q;
    smp(1'h0, 12'h7AA);
    idle();
    q = keep;
    chk(avail, 1'h1);
    rd_all();
    // Post mode on channel 1 with edge-code thresholds, count field 0
    mode = WCE_MODE_POST;
    cnt = 4'h0;
    th[2] = 12'h000;
    th[3] = 12'hFFF;
    e1 = 1'h1;
    rearm = 1'h1;
    @(posedge clk);
    #1 rearm = 1'h0;
    repeat (3) smp(1'h1, 12'hFFE);
    smp(1'h1, 12'h001);
    idle();
    chk(oe, 1'h0);
    q.delete();
    smp(1'h1, 12'hFFF);
    for (i = 0; i < 15; i++) smp(i[0], 12'h300 + 12'(i));
    idle();
    for (i = 0; i < 40 && done !== 1'h1; i++) @(posedge clk);
    chk(done, 1'h1);
    chk(12'(wakes), 12'h002);
    if (done === 1'h1) begin
      rd_all();
    end
    // Pre mode on a fresh buffer: high-side hit at the bound, one sample held
    mode = WCE_MODE_PRE;
    rearm = 1'h1;
    @(posedge clk);
    #1 rearm = 1'h0;
    q.delete();
    smp(1'h0, 12'hE00);
    idle();
    chk(oe, 1'h1);
    chk(done, 1'h1);
    rd_all();
    // Clearing both channel enables drops a standing event
    e0 = 1'h0;
    e1 = 1'h0;
    repeat (2) @(posedge clk);
    #1 chk(oe, 1'h0);
    e0 = 1'h1;
    smp(1'h0, 12'h050);
    idle();
    chk(oe, 1'h1);
    chk(12'(wakes), 12'h004);
    // Global off with rearm leaves the block idle and the event low
    ge = 1'h0;
    rearm = 1'h1;
    @(posedge clk);
    #1 rearm = 1'h0;
    repeat (3) @(posedge clk);
    #1 chk(oe, 1'h0);
    chk(done, 1'h0);
    conclude();
  end
endmodule
`default_nettype wire
